// ---- logic/or_ret_pkg.sv ----
// Shared constants and types for the OR, return and rotate execute slice.
// Assumes a single 25 MHz clock domain and an 8-bit data path.
package or_ret_pkg;

   // Data path and program counter widths.
   localparam int DATA_W      = 8;
   localparam int PC_W        = 10;
   // Return stack depth; the value is a plain default, not a documented figure.
   localparam int STACK_DEPTH = 8;
   localparam int STACK_CNT_W = 4;

   // Reset and fixed values.
   localparam logic [PC_W-1:0]        PC_RESET   = 10'h000;
   localparam logic [PC_W-1:0]        IRQ_VECTOR = 10'h004;
   localparam logic [PC_W-1:0]        PC_STEP    = 10'h001;
   localparam logic [DATA_W-1:0]      BYTE_ZERO  = 8'h00;
   localparam logic [STACK_CNT_W-1:0] CNT_ZERO   = 4'h0;
   localparam logic [STACK_CNT_W-1:0] CNT_STEP   = 4'h1;
   localparam logic [STACK_CNT_W-1:0] CNT_FULL   = 4'h8;

   // Bit position of the byte's top bit, which wraps into bit 0 on a rotate.
   localparam int ROT_MSB = 7;

   // Instruction codes presented to the execute slice.
   typedef enum logic [3:0] {
      OP_IDLE         = 4'h0,
      OP_OR_IMM       = 4'h1,
      OP_OR_MEM       = 4'h2,
      OP_SUB_EXIT     = 4'h3,
      OP_SUB_EXIT_LIT = 4'h4,
      OP_IRQ_EXIT     = 4'h5,
      OP_ROT_LEFT     = 4'h6,
      OP_CALL         = 4'h7,
      OP_ENABLE_IRQ   = 4'h8
   } op_t;

endpackage

// ---- logic/stack_if.sv ----
// Connection between the execute slice and its return-address stack.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface stack_if;
   import or_ret_pkg::*;

   logic            push;       // Store push_addr on top this cycle.
   logic            pop;        // Discard the top entry this cycle.
   logic [PC_W-1:0] push_addr;  // Address to store.
   logic [PC_W-1:0] top_addr;   // Current top entry, zero when empty.
   logic            empty;      // No entries held.
   logic            full;       // Every entry held.

   modport owner (output push, output pop, output push_addr,
                  input top_addr, input empty, input full);
   modport store (input push, input pop, input push_addr,
                  output top_addr, output empty, output full);
endinterface

`default_nettype wire

// ---- logic/ret_stack.sv ----
// Last-in first-out store of return addresses, built from flip-flops.
// Assumes the owner never relies on a push into a full stack.
`timescale 1ns/1ps
`default_nettype none

module ret_stack
   import or_ret_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic arst_n,
   stack_if.store    stk
);

   logic [PC_W-1:0]        entry      [STACK_DEPTH];  // Held addresses.
   logic [PC_W-1:0]        next_entry [STACK_DEPTH];  // Their next values.
   logic [STACK_CNT_W-1:0] count;                     // Entries held.
   logic [STACK_CNT_W-1:0] next_count;                // Its next value.
   logic [STACK_CNT_W-1:0] top_idx;                   // Index of the top entry.

   assign top_idx       = count - CNT_STEP;
   assign stk.empty     = (count == CNT_ZERO);
   assign stk.full      = (count == CNT_FULL);
   assign stk.top_addr  = stk.empty ? PC_RESET : entry[top_idx[2:0]];

   // Push and pop in one cycle replace the top; the execute slice never asserts
   // both, since an interrupt taken at a return leaves the stack as it is.
   always_comb begin
      next_entry = entry;
      next_count = count;
      if (stk.push && stk.pop && !stk.empty) begin
         next_entry[top_idx[2:0]] = stk.push_addr;
      end else if (stk.push && !stk.full) begin
         next_entry[count[2:0]] = stk.push_addr;
         next_count             = count + CNT_STEP;
      end else if (stk.pop && !stk.empty) begin
         next_count = top_idx;
      end
   end

   // Registers only; a push into a full stack is dropped rather than
   // overwriting the oldest return, a limitation of the fixed depth.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= CNT_ZERO;
         for (int i = 0; i < STACK_DEPTH; i++) begin
            entry[i] <= PC_RESET;
         end
      end else begin
         count <= next_count;
         entry <= next_entry;
      end
   end

endmodule // ret_stack

`default_nettype wire

// ---- logic/or_ret_exec.sv ----
// Execute slice for OR, return and left-rotate instructions of an 8-bit core.
// Assumes fetch and operand read happen outside; one instruction per cycle.
// Operation
// - OR literal into work register, update zero
// - OR work register into memory, update zero
// - Subroutine exit pops program counter, flags kept
// - Exit with literal: pop, load work register
// - Interrupt exit with no request waiting pops and sets master enable
// - Pending interrupt serviced before resuming main program
// - Memory byte rotates left, bit seven wraps
`timescale 1ns/1ps
`default_nettype none

module or_ret_exec
   import or_ret_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              arst_n,
   input  wire logic              op_valid,
   input  wire op_t               op_code,
   input  wire logic [DATA_W-1:0] op_literal,
   input  wire logic [PC_W-1:0]   op_target,
   input  wire logic [DATA_W-1:0] mem_addr,
   input  wire logic [DATA_W-1:0] mem_rdata,
   input  wire logic              irq_pending,
   output var  logic [PC_W-1:0]   pc,
   output var  logic [DATA_W-1:0] work_register,
   output var  logic              zero_flag,
   output var  logic              master_irq_enable,
   output var  logic              mem_we,
   output var  logic [DATA_W-1:0] mem_waddr,
   output var  logic [DATA_W-1:0] mem_wdata,
   output var  logic              irq_ack
);

   stack_if stk ();  // Link to the return-address store.

   ret_stack i_ret_stack (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .stk     (stk)
   );

   logic [PC_W-1:0]   next_pc;          // Next program counter.
   logic [DATA_W-1:0] next_work;        // Next work register.
   logic              next_zero;        // Next zero flag.
   logic              next_mie;         // Next master interrupt enable.
   logic              next_mem_we;      // Next memory write strobe.
   logic [DATA_W-1:0] next_mem_waddr;   // Next memory write address.
   logic [DATA_W-1:0] next_mem_wdata;   // Next memory write data.
   logic              next_irq_ack;     // Next interrupt entry pulse.
   logic              take_irq;         // Interrupt preempts this instruction.
   logic [PC_W-1:0]   pc_inc;           // Address of the following instruction.

   assign take_irq = op_valid && irq_pending && master_irq_enable;
   assign pc_inc   = pc + PC_STEP;

   // Decode and execute. An interrupt is only taken on an offered
   // instruction, which is then skipped and re-fetched after the return.
   always_comb begin
      logic [DATA_W-1:0] union_val;
      union_val      = BYTE_ZERO;
      next_pc        = pc;
      next_work      = work_register;
      next_zero      = zero_flag;
      next_mie       = master_irq_enable;
      next_mem_we    = 1'b0;
      next_mem_waddr = mem_waddr;
      next_mem_wdata = mem_wdata;
      next_irq_ack   = 1'b0;
      stk.push       = 1'b0;
      stk.pop        = 1'b0;
      stk.push_addr  = pc;
      if (op_valid && take_irq) begin
         // Interrupt entry saves the current address and masks further entry.
         stk.push     = 1'b1;
         next_pc      = IRQ_VECTOR;
         next_mie     = 1'b0;
         next_irq_ack = 1'b1;
      end else if (op_valid) begin
         unique case (op_code)
            OP_OR_IMM: begin
               union_val = work_register | op_literal;
               next_work = union_val;
               next_zero = (union_val == BYTE_ZERO);
               next_pc   = pc_inc;
            end
            OP_OR_MEM: begin
               union_val      = work_register | mem_rdata;
               next_mem_we    = 1'b1;
               next_mem_waddr = mem_addr;
               next_mem_wdata = union_val;
               next_zero      = (union_val == BYTE_ZERO);
               next_pc        = pc_inc;
            end
            OP_SUB_EXIT: begin
               stk.pop = 1'b1;
               next_pc = stk.top_addr;
            end
            OP_SUB_EXIT_LIT: begin
               stk.pop   = 1'b1;
               next_pc   = stk.top_addr;
               next_work = op_literal;
            end
            OP_IRQ_EXIT: begin
               if (irq_pending) begin
                  // Chain straight into the pending handler: the return
                  // address stays on the stack, as if popped and pushed again.
                  next_pc      = IRQ_VECTOR;
                  next_irq_ack = 1'b1;
                  next_mie     = 1'b0;
               end else begin
                  stk.pop  = 1'b1;
                  next_pc  = stk.top_addr;
                  next_mie = 1'b1;
               end
            end
            OP_ROT_LEFT: begin
               next_mem_we    = 1'b1;
               next_mem_waddr = mem_addr;
               next_mem_wdata = {mem_rdata[ROT_MSB-1:0], mem_rdata[ROT_MSB]};
               next_pc        = pc_inc;
            end
            OP_CALL: begin
               stk.push      = 1'b1;
               stk.push_addr = pc_inc;
               next_pc       = op_target;
            end
            OP_ENABLE_IRQ: begin
               next_mie = 1'b1;
               next_pc  = pc_inc;
            end
            default: begin
               // Idle and unused codes simply advance.
               next_pc = pc_inc;
            end
         endcase
      end
   end

   // Architectural state and output strobes, registered only.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pc                <= PC_RESET;
         work_register     <= BYTE_ZERO;
         zero_flag         <= 1'b0;
         master_irq_enable <= 1'b0;
         mem_we            <= 1'b0;
         mem_waddr         <= BYTE_ZERO;
         mem_wdata         <= BYTE_ZERO;
         irq_ack           <= 1'b0;
      end else begin
         pc                <= next_pc;
         work_register     <= next_work;
         zero_flag         <= next_zero;
         master_irq_enable <= next_mie;
         mem_we            <= next_mem_we;
         mem_waddr         <= next_mem_waddr;
         mem_wdata         <= next_mem_wdata;
         irq_ack           <= next_irq_ack;
      end
   end

   // Checks on the executed results.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   // Issue of one opcode that is not preempted.
   sequence s_run(op_t c);
      op_valid && !take_irq && op_code == c;
   endsequence
   // A call that the stack can still hold; a dropped push proves nothing.
   sequence s_call;
      op_valid && !take_irq && op_code == OP_CALL && !stk.full;
   endsequence
   sequence s_ret;
      s_run(OP_SUB_EXIT);
   endsequence
   // Interrupt exit with no request waiting: a plain return.
   sequence s_exit_clear;
      s_run(OP_IRQ_EXIT) ##0 !irq_pending;
   endsequence
   // Interrupt exit with a request waiting: chains into the handler.
   sequence s_exit_chain;
      s_run(OP_IRQ_EXIT) ##0 irq_pending;
   endsequence
   // Interrupt entry while the stack still has room for the return address.
   sequence s_entry;
      take_irq && !stk.full;
   endsequence

   or_imm_result_a: assert property (s_run(OP_OR_IMM) |=>
      work_register == ($past(work_register) | $past(op_literal))
      && zero_flag == (work_register == BYTE_ZERO))
      else $error("OR literal result or zero flag wrong");
   or_mem_store_a: assert property (s_run(OP_OR_MEM) |=>
      mem_we && mem_waddr == $past(mem_addr)
      && mem_wdata == ($past(work_register) | $past(mem_rdata))
      && $stable(work_register) && zero_flag == (mem_wdata == BYTE_ZERO))
      else $error("OR to memory store wrong");
   sub_exit_pop_a: assert property (s_ret |=>
      pc == $past(stk.top_addr) && $stable(zero_flag) && !mem_we)
      else $error("Subroutine exit did not restore address");
   lit_exit_load_a: assert property (s_run(OP_SUB_EXIT_LIT) |=>
      work_register == $past(op_literal) && pc == $past(stk.top_addr)
      && $stable(zero_flag))
      else $error("Exit with literal wrong");
   irq_exit_enable_a: assert property (s_exit_clear |=>
      master_irq_enable && pc == $past(stk.top_addr) && $stable(zero_flag))
      else $error("Interrupt exit did not re-enable");
   irq_chain_a: assert property (s_exit_chain |=>
      irq_ack && pc == IRQ_VECTOR && $stable(stk.top_addr))
      else $error("Pending interrupt not serviced first");
   rotate_left_a: assert property (s_run(OP_ROT_LEFT) |=>
      mem_we && mem_wdata == {$past(mem_rdata[ROT_MSB-1:0]), $past(mem_rdata[ROT_MSB])}
      && $stable(zero_flag))
      else $error("Rotate left result wrong");
   stack_lifo_a: assert property (s_call ##1 s_ret |=>
      pc == $past(pc, 2) + PC_STEP)
      else $error("Return did not reach latest call site");
   // Entry must leave the interrupted address on top, so that the matching
   // exit comes back to the skipped instruction.
   irq_entry_a: assert property (s_entry |=>
      irq_ack && pc == IRQ_VECTOR && !master_irq_enable && stk.top_addr == $past(pc))
      else $error("Interrupt entry did not save return address");

endmodule // or_ret_exec

`default_nettype wire

// ---- verif/or_return_rotate_execute_bench.sv ----
// Self-checking bench for the OR, return and rotate execute slice.
// Assumes the package and the execute slice with its own stack are compiled first.
`timescale 1ns/1ps
`default_nettype none

module or_return_rotate_execute_bench;
   import or_ret_pkg::*;

   // One expected set of registered outputs, one cycle after an offer.
   typedef struct packed {
      logic [PC_W-1:0]   pc;
      logic [DATA_W-1:0] work;
      logic              zero;
      logic              mie;
      logic              we;
      logic [DATA_W-1:0] waddr;
      logic [DATA_W-1:0] wdata;
      logic              ack;
   } note_t;

   logic              sys_clk = 1'b0;  // Bench clock, 40 ns period.
   logic              arst_n  = 1'b0;  // Reset, held low at the start.
   logic              op_valid = 1'b0;
   op_t               op_code = OP_IDLE;
   logic [DATA_W-1:0] op_literal = 8'h00;
   logic [PC_W-1:0]   op_target = 10'h000;
   logic [DATA_W-1:0] mem_addr = 8'h00;
   logic [DATA_W-1:0] mem_rdata = 8'h00;
   logic              irq_pending = 1'b0;
   logic [PC_W-1:0]   pc;              // Observed program counter.
   logic [DATA_W-1:0] work_register;   // Observed work register.
   logic              zero_flag;       // Observed zero flag.
   logic              master_irq_enable; // Observed master enable.
   logic              mem_we;          // Observed write strobe.
   logic [DATA_W-1:0] mem_waddr;       // Observed write address.
   logic [DATA_W-1:0] mem_wdata;       // Observed write data.
   logic              irq_ack;         // Observed entry pulse.
   note_t             seen;            // Outputs gathered for comparison.
   note_t             m;               // Model state.
   note_t             exp_q[$];        // Notes waiting for their result.
   logic [PC_W-1:0]   stk[$];          // Model return stack.
   logic [31:0]       seed = 32'h00013923;
   int                bad_count = 0;
   int                n_compared = 0;
   int                cycles = 0;

   always #20 sys_clk = ~sys_clk;

   or_ret_exec i_or_ret_exec (
      .sys_clk(sys_clk), .arst_n(arst_n), .op_valid(op_valid), .op_code(op_code),
      .op_literal(op_literal), .op_target(op_target), .mem_addr(mem_addr),
      .mem_rdata(mem_rdata), .irq_pending(irq_pending), .pc(pc),
      .work_register(work_register), .zero_flag(zero_flag),
      .master_irq_enable(master_irq_enable), .mem_we(mem_we), .mem_waddr(mem_waddr),
      .mem_wdata(mem_wdata), .irq_ack(irq_ack));

   // Each output keeps one driver; the note shape is assembled here.
   assign seen = {pc, work_register, zero_flag, master_irq_enable, mem_we, mem_waddr,
                  mem_wdata, irq_ack};

   // Xorshift source; a fixed start keeps every run identical.
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic check(input string name, input logic [15:0] got, input logic [15:0] want);
      n_compared++;
      if (got !== want) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, want, got);
      end
   endtask

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // A pop from an empty stack yields address zero, as the slice does.
   function automatic logic [PC_W-1:0] pop_addr();
      if (stk.size() > 0) begin
         return stk.pop_back();
      end
      return 10'h000;
   endfunction

   function automatic void push_addr(input logic [PC_W-1:0] a);
      if (stk.size() < STACK_DEPTH) begin
         stk.push_back(a);
      end
   endfunction

   // Drives one offer at the falling edge and notes what must follow it.
   task automatic issue(input logic v, input op_t op, input logic [DATA_W-1:0] lit,
                        input logic [DATA_W-1:0] addr, input logic [DATA_W-1:0] rd,
                        input logic [PC_W-1:0] tgt, input logic irq);
      logic [DATA_W-1:0] res;
      @(negedge sys_clk);
      op_valid    = v;
      op_code     = op;
      op_literal  = lit;
      mem_addr    = addr;
      mem_rdata   = rd;
      op_target   = tgt;
      irq_pending = irq;
      res = rd | m.work;
      m.we  = 1'b0;
      m.ack = 1'b0;
      if (v && irq && m.mie) begin
         // Entry preempts the offer, which runs again after the return.
         push_addr(m.pc);
         m.pc  = IRQ_VECTOR;
         m.mie = 1'b0;
         m.ack = 1'b1;
      end else if (v) begin
         m.pc = m.pc + PC_STEP;
         case (op)
            OP_OR_IMM: begin
               m.work = m.work | lit;
               m.zero = (m.work == BYTE_ZERO);
            end
            OP_OR_MEM: begin
               m.we = 1'b1;
               m.waddr = addr;
               m.wdata = res;
               m.zero = (res == BYTE_ZERO);
            end
            OP_SUB_EXIT: m.pc = pop_addr();
            OP_SUB_EXIT_LIT: begin
               m.pc = pop_addr();
               m.work = lit;
            end
            OP_IRQ_EXIT: begin
               if (irq) begin
                  m.pc = IRQ_VECTOR;
                  m.ack = 1'b1;
                  m.mie = 1'b0;
               end else begin
                  m.pc = pop_addr();
                  m.mie = 1'b1;
               end
            end
            OP_ROT_LEFT: begin
               m.we = 1'b1;
               m.waddr = addr;
               m.wdata = {rd[ROT_MSB-1:0], rd[ROT_MSB]};
            end
            OP_CALL: begin
               push_addr(m.pc);
               m.pc = tgt;
            end
            OP_ENABLE_IRQ: m.mie = 1'b1;
            default: ;
         endcase
      end
      exp_q.push_back(m);
   endtask

   task automatic rand_op();
      logic [31:0] r;
      logic [31:0] s;
      r = rnd();
      s = rnd();
      issue(r[31:28] != 4'h0, op_t'(r[3:0]), r[11:4], r[19:12], r[27:20], s[9:0],
            s[15:13] == 3'h0);
   endtask

   task automatic do_reset();
      @(negedge sys_clk);
      arst_n = 1'b0;
      op_valid = 1'b0;
      m = '0;
      stk.delete();
      repeat (12) @(posedge sys_clk);
      @(negedge sys_clk);
      arst_n = 1'b1;
   endtask

   // Watcher: each note meets the outputs one edge after its offer.
   initial begin
      note_t e;
      forever begin
         @(posedge sys_clk);
         #1;
         if (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check("pc", 16'(seen.pc), 16'(e.pc));
            check("work", 16'(seen.work), 16'(e.work));
            check("zero", 16'(seen.zero), 16'(e.zero));
            check("mie", 16'(seen.mie), 16'(e.mie));
            check("we", 16'(seen.we), 16'(e.we));
            check("waddr", 16'(seen.waddr), 16'(e.waddr));
            check("wdata", 16'(seen.wdata), 16'(e.wdata));
            check("ack", 16'(seen.ack), 16'(e.ack));
         end
      end
   end

   // Cut a hang short well past the planned length of the run.
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 8000) begin
         bad_count++;
         finish_test();
      end
   end

   initial begin
      do_reset();
      issue(1'b1, OP_OR_IMM, 8'h00, 8'h00, 8'h00, 10'h000, 1'b0);
      for (int i = 1; i < 9; i++) begin
         issue(1'b1, op_t'(i), 8'(rnd()), 8'(rnd()), 8'h81, 10'h155, 1'b0);
      end
      // Nine calls overfill the stack; nine exits unwind it in reverse.
      for (int i = 0; i < 9; i++) begin
         issue(1'b1, OP_CALL, 8'h00, 8'h00, 8'h00, 10'(i * 40 + 16), 1'b0);
      end
      for (int i = 0; i < 9; i++) begin
         issue(1'b1, OP_SUB_EXIT_LIT, 8'(i), 8'h00, 8'h00, 10'h000, 1'b0);
      end
      issue(1'b1, OP_ENABLE_IRQ, 8'h00, 8'h00, 8'h00, 10'h000, 1'b0);
      issue(1'b1, OP_OR_MEM, 8'h00, 8'h3C, 8'h00, 10'h000, 1'b1);
      issue(1'b1, OP_IRQ_EXIT, 8'h00, 8'h00, 8'h00, 10'h000, 1'b1);
      issue(1'b1, OP_IRQ_EXIT, 8'h00, 8'h00, 8'h00, 10'h000, 1'b0);
      repeat (3000) rand_op();
      @(posedge sys_clk);
      #2;
      do_reset();
      repeat (500) rand_op();
      @(posedge sys_clk);
      #2;
      finish_test();
   end

endmodule // or_return_rotate_execute_bench

`default_nettype wire
